// file: slew_consts.svh
// Constants for the slew-rate and range control block
`ifndef SLEW_CONSTS_SVH
`define SLEW_CONSTS_SVH
// System clock rate in Hz
`define CLK_HZ 10000000
// Register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_CFG 8'h04
`define ADDR_DATA 8'h08
`define ADDR_STAT 8'h0C
// Control register field positions
`define CTRL_RANGE_LSB 0
`define CTRL_SLEW_EN_BIT 4
`define CTRL_STEP_LSB 5
`define CTRL_RATE_LSB 8
`define CTRL_OVR_BIT 14
`define CTRL_CLRSEL_BIT 15
// Configuration register field positions
`define CFG_DUAL_BIT 8
`define CFG_IRANGE_LSB 9
// Status register field position
`define STAT_SLEW_BIT 1
// Reset values
`define CTRL_RST 13'h0000
`define CFG_RST 3'h0
`define DATA_RST 16'h0000
// Range code that is refused
`define RANGE_BAD 3'h4
// Clear levels
`define CLEAR_ZERO 16'h0000
`define CLEAR_MID 16'h8000
// Update frequencies in Hz, one per rate code
`define SR_HZ0 258065
`define SR_HZ1 200000
`define SR_HZ2 153845
`define SR_HZ3 131145
`define SR_HZ4 115940
`define SR_HZ5 69565
`define SR_HZ6 37560
`define SR_HZ7 25805
`define SR_HZ8 20150
`define SR_HZ9 16030
`define SR_HZ10 10295
`define SR_HZ11 8280
`define SR_HZ12 6900
`define SR_HZ13 5530
`define SR_HZ14 4240
`define SR_HZ15 3300
// Clock cycles per update period, rounded down
`define SR_CNT(f) (12'((`CLK_HZ) / (f)))
`endif

// file: slew_pkg.sv
// Types shared by the slew-rate and range control block
package slew_pkg;
	typedef logic [15:0] code_t;
	// Control register contents
	typedef struct packed {
		logic clear_level_sel;
		logic overrange_enable;
		logic [3:0] slew_update_rate_sel;
		logic [2:0] slew_step_size_sel;
		logic slew_enable;
		logic [2:0] range;
	} ctrl_s;
	// Whole state of the main block
	typedef struct packed {
		ctrl_s ctrl;
		logic dual_output_enable;
		logic [1:0] current_range_sel;
		code_t target;
		code_t applied;
		logic [31:0] rdata;
	} state_s;
	// Whole state of the update tick divider
	typedef struct packed {
		logic [11:0] cnt;
		logic tick;
	} tick_state_s;
endpackage

// file: slew_tick_gen.sv
// Update tick divider for the stepping engine
`timescale 1ns/1ns
`default_nettype none
module slew_tick_gen (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [11:0] period_i,
	output logic tick_o
);
	slew_pkg::tick_state_s q, d;

	// Count to the terminal value, then pulse for one cycle and restart
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (q.cnt >= period_i - 12'h001) begin
			d.cnt = 12'h000;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 12'h001;
		end
	end

	// State register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick_o = q.tick;
endmodule
`default_nettype wire

// file: slew_rate_range_control.sv
// Output slew stepping engine, range decode and APB register file
//
// Operation
// - Rate code picks one of sixteen frequencies
// - With slewing on, data and clear pin changes step; a range change loads the clear level at once
// - Clear pin slews output to zero-scale
// - Status bit 1 shows slew in progress
// - Update rate independent of selected range
// - Range code 100 is refused, kept
// - Range change clears the data register
// - Overrange extends voltage ranges by 10%
// - Single mode range field decode order
// - Dual mode voltage off for 1xx
// - Dual mode current range field decode
// - Control bits 4, 7:5, 11:8 fields
// - Step is two to the step code
// - Data read returns applied stepped value
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "slew_consts.svh"
module slew_rate_range_control (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic output_clear_pin_i,
	output logic [15:0] output_code_o,
	output logic slew_active_flag_o,
	output logic voltage_output_en_o,
	output logic [1:0] voltage_range_o,
	output logic current_output_en_o,
	output logic [1:0] current_range_o,
	output logic overrange_o
);
	slew_pkg::state_s q, d;
	logic tick; // One-cycle update strobe
	logic [11:0] period; // Cycles per update
	logic [15:0] step; // Step size in codes
	logic [15:0] tgt_eff; // Code the engine heads for
	logic [15:0] clr_new; // Clear level after a control write
	logic [2:0] range_new; // Range after refusal check
	logic wr; // Write taken this cycle
	logic setup_rd; // Read setup cycle
	logic mapped; // Address hits a register
	logic slew_active; // Applied code still moving

	// Rate code to divider period; same for every range
	always_comb begin
		case (q.ctrl.slew_update_rate_sel)
			4'h0: period = `SR_CNT(`SR_HZ0);
			4'h1: period = `SR_CNT(`SR_HZ1);
			4'h2: period = `SR_CNT(`SR_HZ2);
			4'h3: period = `SR_CNT(`SR_HZ3);
			4'h4: period = `SR_CNT(`SR_HZ4);
			4'h5: period = `SR_CNT(`SR_HZ5);
			4'h6: period = `SR_CNT(`SR_HZ6);
			4'h7: period = `SR_CNT(`SR_HZ7);
			4'h8: period = `SR_CNT(`SR_HZ8);
			4'h9: period = `SR_CNT(`SR_HZ9);
			4'hA: period = `SR_CNT(`SR_HZ10);
			4'hB: period = `SR_CNT(`SR_HZ11);
			4'hC: period = `SR_CNT(`SR_HZ12);
			4'hD: period = `SR_CNT(`SR_HZ13);
			4'hE: period = `SR_CNT(`SR_HZ14);
			default: period = `SR_CNT(`SR_HZ15);
		endcase
	end

	// Divider producing the update strobe
	slew_tick_gen u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.period_i(period),
		.tick_o(tick)
	);

	// Bus decode; zero-wait slave so every access ends in one cycle
	assign pready_o = 1'b1;
	assign wr = psel_i && penable_i && pwrite_i;
	assign setup_rd = psel_i && !penable_i && !pwrite_i;
	assign mapped = (paddr_i == `ADDR_CTRL) || (paddr_i == `ADDR_CFG) ||
		(paddr_i == `ADDR_DATA) || (paddr_i == `ADDR_STAT);
	assign pslverr_o = psel_i && penable_i && !mapped;

	// Step size is a power of two of the step code
	assign step = 16'h0001 << q.ctrl.slew_step_size_sel;
	// Clear pin heads the output for zero-scale
	assign tgt_eff = output_clear_pin_i ? `CLEAR_ZERO : q.target;
	assign slew_active = q.applied != tgt_eff;

	// Refused range code leaves the held value in place
	assign range_new = (pwdata_i[`CTRL_RANGE_LSB +: 3] == `RANGE_BAD) ?
		q.ctrl.range : pwdata_i[`CTRL_RANGE_LSB +: 3];
	// Midscale only for bipolar voltage ranges with the level select set
	assign clr_new = (pwdata_i[`CTRL_CLRSEL_BIT] && !range_new[2] && range_new[1]) ?
		`CLEAR_MID : `CLEAR_ZERO;

	// Next-state logic: stepping engine, then register writes
	always_comb begin
		d = q;
		// Stepping engine
		if (!q.ctrl.slew_enable) begin
			d.applied = tgt_eff; // Jump straight to the target
		end else if (tick && slew_active) begin
			if (q.applied < tgt_eff) begin
				if (tgt_eff - q.applied <= step) begin
					d.applied = tgt_eff;
				end else begin
					d.applied = q.applied + step;
				end
			end else begin
				if (q.applied - tgt_eff <= step) begin
					d.applied = tgt_eff;
				end else begin
					d.applied = q.applied - step;
				end
			end
		end
		// Register writes take effect at the access edge
		if (wr) begin
			case (paddr_i)
				`ADDR_CTRL: begin
					d.ctrl.range = range_new;
					d.ctrl.slew_enable = pwdata_i[`CTRL_SLEW_EN_BIT];
					d.ctrl.slew_step_size_sel = pwdata_i[`CTRL_STEP_LSB +: 3];
					d.ctrl.slew_update_rate_sel = pwdata_i[`CTRL_RATE_LSB +: 4];
					d.ctrl.overrange_enable = pwdata_i[`CTRL_OVR_BIT];
					d.ctrl.clear_level_sel = pwdata_i[`CTRL_CLRSEL_BIT];
					// New range wipes the data held for the old one
					if (range_new != q.ctrl.range) begin
						d.target = clr_new;
						d.applied = clr_new;
					end
				end
				`ADDR_CFG: begin
					d.dual_output_enable = pwdata_i[`CFG_DUAL_BIT];
					d.current_range_sel = pwdata_i[`CFG_IRANGE_LSB +: 2];
				end
				// Without slewing the engine follows on the next cycle
				`ADDR_DATA: d.target = pwdata_i[15:0];
				default: d.target = q.target;
			endcase
		end
		// Read data captured in the setup cycle
		if (setup_rd) begin
			case (paddr_i)
				`ADDR_CTRL: d.rdata = {16'h0000, q.ctrl.clear_level_sel, q.ctrl.overrange_enable,
					2'h0, q.ctrl.slew_update_rate_sel, q.ctrl.slew_step_size_sel,
					q.ctrl.slew_enable, 1'b0, q.ctrl.range};
				`ADDR_CFG: d.rdata = {21'h000000, q.current_range_sel, q.dual_output_enable, 8'h00};
				`ADDR_DATA: d.rdata = {16'h0000, q.applied};
				`ADDR_STAT: d.rdata = {30'h00000000, slew_active, 1'b0};
				default: d.rdata = 32'h00000000;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q.ctrl <= `CTRL_RST;
			{q.current_range_sel, q.dual_output_enable} <= `CFG_RST;
			q.target <= `DATA_RST;
			q.applied <= `DATA_RST;
			q.rdata <= 32'h00000000;
		end else begin
			q <= d;
		end
	end

	// Range decode: dual mode splits the two fields, single mode uses range alone
	always_comb begin
		if (q.dual_output_enable) begin
			voltage_output_en_o = !q.ctrl.range[2];
			current_output_en_o = q.current_range_sel != 2'h0;
			current_range_o = q.current_range_sel;
		end else begin
			voltage_output_en_o = !q.ctrl.range[2];
			current_output_en_o = q.ctrl.range[2] && (q.ctrl.range[1:0] != 2'h0);
			current_range_o = q.ctrl.range[2] ? q.ctrl.range[1:0] : 2'h0;
		end
		voltage_range_o = q.ctrl.range[1:0];
	end

	// Overrange stretches only an active voltage output
	assign overrange_o = q.ctrl.overrange_enable && voltage_output_en_o;
	assign output_code_o = q.applied;
	assign slew_active_flag_o = slew_active;
	assign prdata_o = q.rdata;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Refused range code keeps the old range
	property p_range_refused;
		wr && paddr_i == `ADDR_CTRL && pwdata_i[2:0] == `RANGE_BAD |=> q.ctrl.range == $past(q.ctrl.range);
	endproperty
	a_range_refused: assert property (p_range_refused) else $error("refused range was stored");

	// Range change loads the clear level into both codes
	property p_range_clear;
		wr && paddr_i == `ADDR_CTRL && range_new != q.ctrl.range |=> q.target == $past(clr_new)
			&& output_code_o == $past(clr_new);
	endproperty
	a_range_clear: assert property (p_range_clear) else $error("range change did not clear data");

	// Without slewing the output follows the target one cycle later
	property p_no_slew;
		!q.ctrl.slew_enable && !wr |=> output_code_o == $past(tgt_eff);
	endproperty
	a_no_slew: assert property (p_no_slew) else $error("output did not follow target");

	// Between ticks a slewing output holds still
	property p_hold;
		q.ctrl.slew_enable && !tick && !wr |=> $stable(output_code_o);
	endproperty
	a_hold: assert property (p_hold) else $error("output moved without a tick");

	// Upward step is exactly one step size when far from target
	property p_step_up;
		q.ctrl.slew_enable && tick && !wr && tgt_eff > q.applied && tgt_eff - q.applied > step
			|=> output_code_o == $past(q.applied) + $past(step);
	endproperty
	a_step_up: assert property (p_step_up) else $error("wrong step size");

	// Last step lands on the target
	property p_clamp;
		q.ctrl.slew_enable && tick && !wr && slew_active && (tgt_eff > q.applied ?
			tgt_eff - q.applied : q.applied - tgt_eff) <= step |=> output_code_o == $past(tgt_eff);
	endproperty
	a_clamp: assert property (p_clamp) else $error("final step missed target");

	// Clear pin walks the output down rather than jumping
	property p_clear_slew;
		output_clear_pin_i && q.ctrl.slew_enable && tick && !wr && q.applied > step
			|=> output_code_o == $past(q.applied) - $past(step);
	endproperty
	a_clear_slew: assert property (p_clear_slew) else $error("clear did not slew down");

	// Status read reflects the slew flag seen at setup
	property p_status;
		setup_rd && paddr_i == `ADDR_STAT |=> prdata_o[`STAT_SLEW_BIT] == $past(slew_active);
	endproperty
	a_status: assert property (p_status) else $error("status slew bit wrong");

	// Data read returns the applied code
	property p_data_rd;
		setup_rd && paddr_i == `ADDR_DATA |=> prdata_o[15:0] == $past(output_code_o);
	endproperty
	a_data_rd: assert property (p_data_rd) else $error("data read not applied code");

	// Dual mode current disabled by code 00
	property p_dual_cur;
		q.dual_output_enable && q.current_range_sel == 2'h0 |-> !current_output_en_o;
	endproperty
	a_dual_cur: assert property (p_dual_cur) else $error("current output not disabled");

	// Downward step is exactly one step size when far from target
	property p_step_down;
		q.ctrl.slew_enable && tick && !wr && q.applied > tgt_eff && q.applied - tgt_eff > step
			|=> output_code_o == $past(q.applied) - $past(step);
	endproperty
	a_step_down: assert property (p_step_down) else $error("wrong downward step");

	// Overrange never reaches a disabled voltage output
	property p_ovr_off;
		!voltage_output_en_o |-> !overrange_o;
	endproperty
	a_ovr_off: assert property (p_ovr_off) else $error("overrange on disabled voltage output");

	// Dual mode with a 1xx range drops voltage and keeps the current field
	property p_dual_volt;
		q.dual_output_enable && q.ctrl.range[2]
			|-> !voltage_output_en_o && current_range_o == q.current_range_sel;
	endproperty
	a_dual_volt: assert property (p_dual_volt) else $error("dual mode voltage not disabled");

	// Single mode current codes pick the current output and its range
	property p_single_cur;
		!q.dual_output_enable && q.ctrl.range[2]
			|-> current_output_en_o && !voltage_output_en_o && current_range_o == q.ctrl.range[1:0];
	endproperty
	a_single_cur: assert property (p_single_cur) else $error("single mode current decode wrong");

	// Control write lands the slew fields in their bit positions
	property p_ctrl_fields;
		wr && paddr_i == `ADDR_CTRL |=> q.ctrl.slew_enable == $past(pwdata_i[`CTRL_SLEW_EN_BIT])
			&& q.ctrl.slew_step_size_sel == $past(pwdata_i[`CTRL_STEP_LSB +: 3])
			&& q.ctrl.slew_update_rate_sel == $past(pwdata_i[`CTRL_RATE_LSB +: 4]);
	endproperty
	a_ctrl_fields: assert property (p_ctrl_fields) else $error("slew control fields not stored");

	// Configuration write stores the dual enable and current range
	property p_cfg_fields;
		wr && paddr_i == `ADDR_CFG |=> q.dual_output_enable == $past(pwdata_i[`CFG_DUAL_BIT])
			&& q.current_range_sel == $past(pwdata_i[`CFG_IRANGE_LSB +: 2]);
	endproperty
	a_cfg_fields: assert property (p_cfg_fields) else $error("configuration fields not stored");
endmodule
`default_nettype wire

// file: slew_rate_range_control_test.sv
// Self-checking bench for the slew-rate and range control block
`timescale 1ns/1ns
`default_nettype none
`include "slew_consts.svh"
module slew_rate_range_control_test;
	logic clk_i = 1'b0; // 10 MHz system clock
	logic rst_i = 1'b1; // Held high for the first 12 cycles
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h00000000;
	logic output_clear_pin_i = 1'b0;
	logic [31:0] prdata_o;
	logic pready_o, pslverr_o, slew_active_flag_o, voltage_output_en_o, current_output_en_o, overrange_o;
	logic [15:0] output_code_o;
	logic [1:0] voltage_range_o, current_range_o;
	int mismatches = 0; // Failed comparisons
	int samples_checked = 0; // All comparisons
	logic [31:0] rd; // Last read data
	logic er; // Last error response
	logic [15:0] seen[$]; // Codes seen while stepping
	int gap; // Cycles between first two steps
	slew_rate_range_control dut_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .output_clear_pin_i(output_clear_pin_i), .output_code_o(output_code_o),
		.slew_active_flag_o(slew_active_flag_o), .voltage_output_en_o(voltage_output_en_o),
		.voltage_range_o(voltage_range_o), .current_output_en_o(current_output_en_o),
		.current_range_o(current_range_o), .overrange_o(overrange_o));
	// Free-running clock, 100 ns period
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	// One compare for every kind of result; unknowns never match
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// APB transfer; request held until pready is sampled high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// Only the watchdog ends a wait that never sees ready
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	// Records each new code until the slew ends; bounded so a stuck flag cannot hang
	task observe();
		int n;
		int t0;
		logic [15:0] prev;
		seen.delete();
		gap = 0;
		@(negedge clk_i);
		chk(slew_active_flag_o, 1'b1, "slew flag set");
		prev = output_code_o;
		for (n = 0; n < 8000 && slew_active_flag_o === 1'b1; n++) begin
			@(negedge clk_i);
			if (output_code_o !== prev) begin
				if (seen.size() == 1)
					gap = n - t0;
				t0 = n;
				seen.push_back(output_code_o);
				prev = output_code_o;
			end
		end
		chk(slew_active_flag_o, 1'b0, "slew flag clear at end");
	endtask
	// Closing point of every run
	task give_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Reset values of every register and of the voltage enable, voltage range and current enable outputs
	task test_reset();
		int i;
		for (i = 0; i < 4; i++) begin
			apb(1'b0, 8'(i * 4), 32'h00000000);
			chk(rd, 32'h00000000, "reset read");
		end
		chk({voltage_output_en_o, voltage_range_o, current_output_en_o}, 4'h8, "reset decode");
		apb(1'b0, 8'h10, 32'h00000000);
		chk(er, 1'b1, "unmapped error");
		chk(rd, 32'h00000000, "unmapped read");
		$display("test reset done");
	endtask
	// Range change clears data, refused code keeps range, overrange on voltage only
	task test_range();
		apb(1'b1, `ADDR_DATA, 32'h00001234);
		// Without slewing the applied code follows one cycle after the write
		repeat (2) @(negedge clk_i);
		chk(output_code_o, 16'h1234, "direct update");
		apb(1'b1, `ADDR_CTRL, 32'h0000C003);
		@(negedge clk_i);
		chk(output_code_o, `CLEAR_MID, "clear to midscale");
		chk({voltage_output_en_o, voltage_range_o, overrange_o}, 4'hF, "bipolar 10 V with overrange");
		apb(1'b1, `ADDR_CTRL, 32'h0000C004);
		apb(1'b0, `ADDR_CTRL, 32'h00000000);
		chk(rd, 32'h0000C003, "refused range kept");
		apb(1'b1, `ADDR_CTRL, 32'h0000C005);
		@(negedge clk_i);
		chk({voltage_output_en_o, current_output_en_o, current_range_o, overrange_o}, 5'h0A, "4-20 mA");
		chk(output_code_o, `CLEAR_ZERO, "clear to zero on current");
		$display("test range done");
	endtask
	// Dual mode decode of both range fields
	task test_dual();
		int i;
		for (i = 0; i < 4; i++) begin
			apb(1'b1, `ADDR_CFG, 32'h00000100 | 32'(i << 9));
			@(negedge clk_i);
			chk({voltage_output_en_o, current_output_en_o, current_range_o}, {1'b0, 1'(i != 0), 2'(i)}, "dual 1xx");
		end
		apb(1'b1, `ADDR_CTRL, 32'h00000002);
		@(negedge clk_i);
		chk({voltage_output_en_o, voltage_range_o, current_output_en_o}, 4'hD, "dual voltage plus current");
		apb(1'b1, `ADDR_CFG, 32'h00000000);
		$display("test dual done");
	endtask
	// Fastest rate, largest step, clamped final step, mid-slew read, clear pin slew
	task test_slew_fast();
		apb(1'b1, `ADDR_CTRL, 32'h000000F0);
		apb(1'b1, `ADDR_DATA, 32'h000000C0);
		apb(1'b0, `ADDR_DATA, 32'h00000000);
		chk(1'(rd === 32'h00000000 || rd === 32'h00000080), 1'b1, "instantaneous read");
		observe();
		chk(seen.size(), 2, "two steps");
		chk({seen[0], seen[1]}, 32'h008000C0, "step then clamp");
		chk(gap, 38, "update period code 0");
		@(posedge clk_i);
		output_clear_pin_i <= 1'b1;
		observe();
		chk({seen[0], seen[1]}, 32'h00400000, "clear slews to zero");
		@(posedge clk_i);
		output_clear_pin_i <= 1'b0;
		observe();
		chk(output_code_o, 16'h00C0, "back to target");
		$display("test slew fast done");
	endtask
	// Slowest rate on a current range: same divider whatever the range
	task test_slew_slow();
		apb(1'b1, `ADDR_CTRL, 32'h00000FF5);
		apb(1'b1, `ADDR_DATA, 32'h00000100);
		observe();
		chk({seen[0], seen[1]}, 32'h00800100, "slow steps");
		chk(gap, 3030, "update period code 15");
		apb(1'b0, `ADDR_STAT, 32'h00000000);
		chk(rd, 32'h00000000, "status idle");
		$display("test slew slow done");
	endtask
	// Watchdog: expected run is under 10000 cycles
	initial begin
		#(40000 * 100);
		mismatches++;
		give_verdict();
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		test_reset();
		test_range();
		test_dual();
		test_slew_fast();
		test_slew_slow();
		give_verdict();
	end
endmodule
`default_nettype wire
